// ### inc/jtp_pkg.sv
package jtp_pkg;

    // instruction register
    localparam int         IR_W         = 4;
    localparam logic [3:0] IR_EXTEST    = 4'h0;
    localparam logic [3:0] IR_SAMPLE    = 4'h1;
    localparam logic [3:0] IR_IDCODE    = 4'h2;
    localparam logic [3:0] IR_HIGHZ     = 4'h3;
    localparam logic [3:0] IR_BYPASS    = 4'hf;
    localparam logic [3:0] IR_CAPTURE   = 4'h1;

    // identification word layout
    localparam int         ID_W         = 32;
    localparam int         ID_VER_LSB   = 28;
    localparam int         ID_PART_LSB  = 12;
    localparam int         ID_MAKER_LSB = 1;
    localparam logic       ID_FIXED_ONE = 1'b1;

    // boundary cells
    localparam int         BS_IN_W      = 8;
    localparam int         BS_OUT_W     = 8;
    localparam int         BS_W         = BS_IN_W + BS_OUT_W + 1;

    // synchroniser depth
    localparam int         SYNC_STAGES  = 2;

    typedef enum logic [3:0] {
        JTP_TLR, JTP_RTI, JTP_SELDR, JTP_CAPDR, JTP_SHDR, JTP_EX1DR,
        JTP_PAUDR, JTP_EX2DR, JTP_UPDDR, JTP_SELIR, JTP_CAPIR,
        JTP_SHIR, JTP_EX1IR, JTP_PAUIR, JTP_EX2IR, JTP_UPDIR
    } jtp_state_e;

    typedef enum logic [1:0] {
        JTP_SEL_BSR, JTP_SEL_ID, JTP_SEL_BYP
    } jtp_sel_e;

    // word handed from test clock side to the pad side
    typedef struct packed {
        logic [BS_OUT_W-1:0] dat;
        logic                oe;
    } jtp_upd_s;

endpackage

// ### hdl/jtp_tap.sv
`timescale 1ns/100ps

module jtp_tap
    import jtp_pkg::*;
#(
    parameter logic [3:0]  ID_VERSION = 4'h5,    // arbitrary value
    parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h2a5  // arbitrary value
)(
    // system side
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // test port
    input  wire logic                         testClk,
    input  wire logic                         trst_n,
    input  wire logic                         tms,
    input  wire logic                         tdi,
    output logic                              tdo,
    output logic                              tdoOe_n,
    // core logic
    input  wire logic [jtp_pkg::BS_OUT_W-1:0] coreOut,
    input  wire logic                         coreOe,
    // pads
    input  wire logic [jtp_pkg::BS_IN_W-1:0]  pinIn,
    output logic [jtp_pkg::BS_OUT_W-1:0]      padOut,
    output logic                              padOe_n
);
    import jtp_pkg::*;

    function automatic jtp_sel_e decodeSel(input logic [IR_W-1:0] ir);
        jtp_sel_e s;
        if (ir == IR_EXTEST || ir == IR_SAMPLE)
            s = JTP_SEL_BSR;
        else if (ir == IR_IDCODE)
            s = JTP_SEL_ID;
        else
            s = JTP_SEL_BYP;
        return s;
    endfunction

    localparam logic [ID_W-1:0] ID_WORD =
        {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_ONE};

    jtp_state_e          state_q;
    jtp_state_e          state_d;
    logic [IR_W-1:0]     irSh_q;
    logic [IR_W-1:0]     instr_q;
    logic                byp_q;
    logic [ID_W-1:0]     idSh_q;
    logic [BS_W-1:0]     bsSh_q;
    jtp_upd_s            upd_q;
    logic                updTgl_q;
    logic [BS_IN_W-1:0]  pinS1_q;
    logic [BS_IN_W-1:0]  pinS2_q;
    jtp_upd_s            coreS1_q;
    jtp_upd_s            coreS2_q;
    jtp_sel_e            sel;
    logic                serOut;

    assign sel = decodeSel(instr_q);

    // controller
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            JTP_TLR:   state_d = tms ? JTP_TLR   : JTP_RTI;
            JTP_RTI:   state_d = tms ? JTP_SELDR : JTP_RTI;
            JTP_SELDR: state_d = tms ? JTP_SELIR : JTP_CAPDR;
            JTP_CAPDR: state_d = tms ? JTP_EX1DR : JTP_SHDR;
            JTP_SHDR:  state_d = tms ? JTP_EX1DR : JTP_SHDR;
            JTP_EX1DR: state_d = tms ? JTP_UPDDR : JTP_PAUDR;
            JTP_PAUDR: state_d = tms ? JTP_EX2DR : JTP_PAUDR;
            JTP_EX2DR: state_d = tms ? JTP_UPDDR : JTP_SHDR;
            JTP_UPDDR: state_d = tms ? JTP_SELDR : JTP_RTI;
            JTP_SELIR: state_d = tms ? JTP_TLR   : JTP_CAPIR;
            JTP_CAPIR: state_d = tms ? JTP_EX1IR : JTP_SHIR;
            JTP_SHIR:  state_d = tms ? JTP_EX1IR : JTP_SHIR;
            JTP_EX1IR: state_d = tms ? JTP_UPDIR : JTP_PAUIR;
            JTP_PAUIR: state_d = tms ? JTP_EX2IR : JTP_PAUIR;
            JTP_EX2IR: state_d = tms ? JTP_UPDIR : JTP_SHIR;
            JTP_UPDIR: state_d = tms ? JTP_SELDR : JTP_RTI;
            default:   state_d = JTP_TLR;
        endcase
    end

    // tms and tdi are launched by the tester on this same clock
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            state_q <= JTP_TLR;
        else
            state_q <= state_d;
    end

    // instruction register
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            irSh_q <= IR_CAPTURE;
        else if (state_q == JTP_CAPIR)
            irSh_q <= IR_CAPTURE;
        else if (state_q == JTP_SHIR)
            irSh_q <= {tdi, irSh_q[IR_W-1:1]};
    end

    // idcode after reset so a blind scan reads the identity
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            instr_q <= IR_IDCODE;
        else if (state_q == JTP_TLR)
            instr_q <= IR_IDCODE;
        else if (state_q == JTP_UPDIR)
            instr_q <= irSh_q;
    end

    // pins and core outputs sampled as a snapshot; a word captured while
    // the core is switching may mix old and new bits
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
        begin
            pinS1_q  <= '0;
            pinS2_q  <= '0;
            coreS1_q <= '0;
            coreS2_q <= '0;
        end
        else
        begin
            pinS1_q  <= pinIn;
            pinS2_q  <= pinS1_q;
            coreS1_q <= {coreOut, coreOe};
            coreS2_q <= coreS1_q;
        end
    end

    // data registers; only the selected one moves, the rest stay frozen
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            byp_q <= 1'b0;
        else if (sel == JTP_SEL_BYP)
        begin
            if (state_q == JTP_CAPDR)
                byp_q <= 1'b0;
            else if (state_q == JTP_SHDR)
                byp_q <= tdi;
        end
    end

    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            idSh_q <= '0;
        else if (sel == JTP_SEL_ID)
        begin
            if (state_q == JTP_CAPDR)
                idSh_q <= ID_WORD;
            else if (state_q == JTP_SHDR)
                idSh_q <= {tdi, idSh_q[ID_W-1:1]};
        end
    end

    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
            bsSh_q <= '0;
        else if (sel == JTP_SEL_BSR)
        begin
            if (state_q == JTP_CAPDR)
                bsSh_q <= {coreS2_q, pinS2_q};
            else if (state_q == JTP_SHDR)
                bsSh_q <= {tdi, bsSh_q[BS_W-1:1]};
        end
    end

    // update latch; preload fills it before extest drives it out
    always_ff @(posedge testClk or negedge trst_n)
    begin
        if (!trst_n)
        begin
            upd_q    <= '0;
            updTgl_q <= 1'b0;
        end
        else if (state_q == JTP_UPDDR && sel == JTP_SEL_BSR)
        begin
            upd_q    <= bsSh_q[BS_W-1:BS_IN_W];
            updTgl_q <= ~updTgl_q;
        end
    end

    // serial output changes on the falling edge
    always_comb
    begin
        serOut = byp_q;
        if (state_q == JTP_SHIR)
            serOut = irSh_q[0];
        else if (sel == JTP_SEL_ID)
            serOut = idSh_q[0];
        else if (sel == JTP_SEL_BSR)
            serOut = bsSh_q[0];
    end

    always_ff @(negedge testClk or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo     <= 1'b0;
            tdoOe_n <= 1'b1;
        end
        else
        begin
            tdo     <= serOut;
            tdoOe_n <= !(state_q == JTP_SHDR || state_q == JTP_SHIR);
        end
    end

    // pad side on the system clock
    logic [SYNC_STAGES-1:0] extS_q;
    logic [SYNC_STAGES-1:0] hizS_q;
    logic [SYNC_STAGES-1:0] tglS_q;
    logic                   tglSeen_q;
    jtp_upd_s               updC_q;
    logic                   extestMode;
    logic                   highzMode;

    assign extestMode = (instr_q == IR_EXTEST);
    assign highzMode  = (instr_q == IR_HIGHZ);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extS_q <= '0;
            hizS_q <= '0;
            tglS_q <= '0;
        end
        else
        begin
            extS_q <= {extS_q[0], extestMode};
            hizS_q <= {hizS_q[0], highzMode};
            tglS_q <= {tglS_q[0], updTgl_q};
        end
    end

    // latch is stable for several test clocks after each toggle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tglSeen_q <= 1'b0;
            updC_q    <= '0;
        end
        else if (tglS_q[1] != tglSeen_q)
        begin
            tglSeen_q <= tglS_q[1];
            updC_q    <= upd_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            padOut  <= '0;
            padOe_n <= 1'b1;
        end
        else if (hizS_q[1])
        begin
            padOut  <= coreOut;
            padOe_n <= 1'b1;
        end
        else if (extS_q[1])
        begin
            padOut  <= updC_q.dat;
            padOe_n <= !updC_q.oe;
        end
        else
        begin
            padOut  <= coreOut;
            padOe_n <= !coreOe;
        end
    end

    // checks
    sequence s_exitDr;
        (state_q == JTP_EX1DR || state_q == JTP_EX2DR);
    endsequence

    sequence s_fiveHigh;
        tms [*5];
    endsequence

    property p_exitUpdate;
        @(posedge testClk) disable iff (!trst_n)
        s_exitDr ##0 tms |=> state_q == JTP_UPDDR;
    endproperty
    a_exitUpdate: assert property (p_exitUpdate)
        else $error("exit with tms high did not reach update-dr");

    property p_exitHold;
        @(posedge testClk) disable iff (!trst_n)
        s_exitDr |=> $stable(byp_q) && $stable(idSh_q) && $stable(bsSh_q);
    endproperty
    a_exitHold: assert property (p_exitHold)
        else $error("data register changed in exit state");

    property p_pauseHold;
        @(posedge testClk) disable iff (!trst_n)
        state_q == JTP_PAUDR |=>
            $stable(byp_q) && $stable(idSh_q) && $stable(bsSh_q);
    endproperty
    a_pauseHold: assert property (p_pauseHold)
        else $error("data register changed in pause-dr");

    property p_irShift;
        @(posedge testClk) disable iff (!trst_n)
        state_q == JTP_SHIR |=> irSh_q[IR_W-1] == $past(tdi) &&
            (irSh_q << 1) == ($past(irSh_q) & ~IR_W'(1));
    endproperty
    a_irShift: assert property (p_irShift)
        else $error("instruction bit not shifted in");

    property p_instrHold;
        @(posedge testClk) disable iff (!trst_n)
        state_q != JTP_UPDIR && state_q != JTP_TLR |=> $stable(instr_q);
    endproperty
    a_instrHold: assert property (p_instrHold)
        else $error("instruction changed outside update-ir");

    property p_bypCapture;
        @(posedge testClk) disable iff (!trst_n)
        state_q == JTP_CAPDR && sel == JTP_SEL_BYP |=> byp_q == 1'b0;
    endproperty
    a_bypCapture: assert property (p_bypCapture)
        else $error("bypass stage not cleared on capture");

    property p_idCapture;
        @(posedge testClk) disable iff (!trst_n)
        state_q == JTP_CAPDR && instr_q == IR_IDCODE |=>
            idSh_q == ID_WORD && idSh_q[0] == ID_FIXED_ONE;
    endproperty
    a_idCapture: assert property (p_idCapture)
        else $error("identification word not captured");

    property p_fiveReset;
        @(posedge testClk) disable iff (!trst_n)
        s_fiveHigh |=> state_q == JTP_TLR;
    endproperty
    a_fiveReset: assert property (p_fiveReset)
        else $error("five tms-high cycles did not reset");

    property p_highZ;
        @(posedge clk) disable iff (!rst_n)
        hizS_q[1] |=> padOe_n;
    endproperty
    a_highZ: assert property (p_highZ)
        else $error("pad driven while high-z active");

endmodule // jtp_tap

// ### sim/jtp_tester.sv
`timescale 1ns/100ps

module jtp_tester (
    // test port
    output logic      testClk,
    output logic      trst_n,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // clock stands low between frames
    initial
    begin
        testClk = 1'b0;
        trst_n  = 1'b0;
        tms     = 1'b1;
        tdi     = 1'b0;
    end

    // tdo read just before the rising edge that shifts it on
    task automatic step(input logic m, input logic d, output logic q);
    begin
        tms = m;
        tdi = d;
        #3.75;
        q = tdo;
        #3.75 testClk = 1'b1;
        #7.5 testClk = 1'b0;
    end
    endtask

    // released data line toggles so a stale value never matches
    task automatic idle(input logic m);
        logic q;
    begin
        step(m, ~tdi, q);
    end
    endtask

    task automatic hardReset();
    begin
        trst_n = 1'b0;
        #60 trst_n = 1'b1;
        #10 idle(1'b0);
    end
    endtask

    task automatic softReset();
        int i;
    begin
        for (i = 0; i < 5; i++)
            idle(1'b1);
        idle(1'b0);
    end
    endtask

    // idle to idle; pauseAt below zero skips the pause detour
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        input int pauseAt, output logic [31:0] dout);
        int   i;
        logic q;
    begin
        dout = '0;
        idle(1'b1);
        if (ir)
            idle(1'b1);
        idle(1'b0);
        idle(1'b0);
        for (i = 0; i < n; i++)
        begin
            step((i == n - 1) || (i == pauseAt), din[i], q);
            dout[i] = q;
            if (i == pauseAt && i != n - 1)
            begin
                idle(1'b0);
                idle(1'b0);
                idle(1'b1);
                idle(1'b0);
            end
        end
        idle(1'b1);
        idle(1'b0);
    end
    endtask
endmodule // jtp_tester

// ### sim/test_jtp_tap.sv
`timescale 1ns/100ps

module test_jtp_tap;
    import jtp_pkg::*;

    // arbitrary identification values
    localparam logic [3:0]  VER   = 4'h6;
    localparam logic [15:0] PART  = 16'h5a3c;
    localparam logic [10:0] MAKER = 11'h155;
    localparam logic [31:0] IDW   = {VER, PART, MAKER, 1'b1};

    logic                clk;
    logic                rst_n;
    logic                testClk;
    logic                trst_n;
    logic                tms;
    logic                tdi;
    logic                tdo;
    logic                tdoOe_n;
    logic [BS_OUT_W-1:0] coreOut;
    logic                coreOe;
    logic [BS_IN_W-1:0]  pinIn;
    logic [BS_OUT_W-1:0] padOut;
    logic                padOe_n;
    logic [31:0]         got;
    int                  failures   = 0;
    int                  n_compared = 0;
    int                  cycles     = 0;
    int                  oeLow      = 0;

    jtp_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) DUT (
        .clk(clk), .rst_n(rst_n), .testClk(testClk), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n),
        .coreOut(coreOut), .coreOe(coreOe), .pinIn(pinIn),
        .padOut(padOut), .padOe_n(padOe_n)
    );

    jtp_tester tester (
        .testClk(testClk), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo)
    );

    // rising test clock edges seen with the serial output enabled
    always @(posedge testClk)
        if (tdoOe_n === 1'b0)
            oeLow <= oeLow + 1;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
    begin
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // whole run needs about six hundred cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            summarize();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e,
                         input string what);
    begin
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, g, e);
        end
    end
    endtask

    task automatic settle();
    begin
        repeat (6) @(posedge clk);
        @(negedge clk);
    end
    endtask

    task automatic loadIr(input logic [3:0] code);
    begin
        tester.scan(1'b1, 4, 32'(code), -1, got);
        check(got, 32'h1, "ir capture");
    end
    endtask

    task automatic testIdcode();
        int base;
    begin
        tester.hardReset();
        base = oeLow;
        tester.scan(1'b0, 32, 32'h0, -1, got);
        check(got, IDW, "id after reset");
        check(32'(oeLow - base), 32'd32, "tdo enable span");
        loadIr(IR_IDCODE);
        tester.scan(1'b0, 32, 32'hffffffff, 13, got);
        check(got, IDW, "id across pause");
        tester.scan(1'b0, 32, 32'h0, -1, got);
        check(got, IDW, "id not written");
        $display("idcode test done");
    end
    endtask

    // undefined and high-z codes share the bypass path
    task automatic testBypass();
        logic [3:0] codes [5] = '{4'hf, 4'h3, 4'h4, 4'h7, 4'he};
        int         k;
    begin
        for (k = 0; k < 5; k++)
        begin
            loadIr(codes[k]);
            tester.scan(1'b0, 9, 32'h0b5, -1, got);
            check(got, 32'h16a, "one stage path");
        end
        $display("bypass test done");
    end
    endtask

    task automatic testPads();
    begin
        @(posedge clk);
        coreOut <= 8'h3c;
        coreOe  <= 1'b1;
        loadIr(IR_BYPASS);
        settle();
        check(32'({padOe_n, padOut}), 32'h03c, "bypass pads");
        loadIr(IR_HIGHZ);
        settle();
        check(32'(padOe_n), 32'h1, "pads float");
        loadIr(IR_BYPASS);
        settle();
        check(32'({padOe_n, padOut}), 32'h03c, "pads back");
        $display("pad test done");
    end
    endtask

    task automatic testBoundary();
        logic [16:0] pre;
    begin
        pre = 17'h1a5c3;
        @(posedge clk);
        pinIn   <= 8'h96;
        coreOut <= 8'h4b;
        settle();
        loadIr(IR_SAMPLE);
        tester.scan(1'b0, 17, 32'(pre), -1, got);
        // cells from the top: core data, core enable, then the pins
        check(got, 32'h09796, "sample capture");
        settle();
        check(32'({padOe_n, padOut}), 32'h04b, "preload only");
        loadIr(IR_EXTEST);
        settle();
        // latch takes bits 16..9 as data and bit 8 as enable
        check(32'({padOe_n, padOut}), 32'h0d2, "extest pads");
        tester.softReset();
        tester.scan(1'b0, 32, 32'h0, -1, got);
        check(got, IDW, "mode select reset");
        settle();
        check(32'({padOe_n, padOut}), 32'h04b, "normal pads");
        $display("boundary test done");
    end
    endtask

    initial
    begin
        rst_n   = 1'b0;
        coreOut = 8'h00;
        coreOe  = 1'b0;
        pinIn   = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        testIdcode();
        testBypass();
        testPads();
        testBoundary();
        summarize();
    end
endmodule // test_jtp_tap
